// file: verilog/ext_bus_consts.vh
`ifndef EXT_BUS_CONSTS_VH
`define EXT_BUS_CONSTS_VH

// ----------------------------------------
// address widths
// ----------------------------------------
`define EB_ADDR_W        32
`define EB_PIN_ADDR_W    24

// ----------------------------------------
// byte count code: bytes still to move
// ----------------------------------------
`define EB_SZ_FOUR       2'h0
`define EB_SZ_ONE        2'h1
`define EB_SZ_TWO        2'h2
`define EB_SZ_THREE      2'h3

// ----------------------------------------
// burst and request queue
// ----------------------------------------
`define EB_LAST_BEAT     2'h3
`define EB_FIFO_DEPTH    8
`define EB_FIFO_AW       3
`define EB_REQ_W         43

// ----------------------------------------
// request word fields
// ----------------------------------------
`define EB_F_ADDR_LO     0
`define EB_F_ADDR_HI     31
`define EB_F_READ        32
`define EB_F_SIZE_LO     33
`define EB_F_SIZE_HI     34
`define EB_F_BURST       35
`define EB_F_CLASS_LO    36
`define EB_F_CLASS_HI    39
`define EB_F_RESERVE     40
`define EB_F_TRACE       41
`define EB_F_COND        42

// ----------------------------------------
// pin input sync vector positions
// ----------------------------------------
`define EB_IN_W          6
`define EB_IN_CLK        0
`define EB_IN_TS         1
`define EB_IN_BURST      2
`define EB_IN_ACK        3
`define EB_IN_DROP       4
`define EB_IN_ABORT      5

`endif

// file: verilog/word_ram.v
`timescale 1ns/1ps

// ----------------------------------------
// small register-file memory, registered read
// ----------------------------------------
module word_ram #(
  parameter W  = 43,
  parameter AW = 3
) (
  input  wire          ref_clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  input  wire [AW-1:0] raddr,
  output reg  [W-1:0]  rdata
);

  reg [W-1:0] mem [0:(1<<AW)-1];

  // no reset: contents are meaningless until written
  always @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // word_ram

// file: verilog/req_fifo.v
`timescale 1ns/1ps

// ----------------------------------------
// request queue with valid/ready on both sides
// ----------------------------------------
module req_fifo #(
  parameter W     = 43,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output reg          in_ready,
  output reg          out_valid,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);

  localparam [31:0] DEPTH_WORD = DEPTH;
  localparam [AW:0] FULL_CNT   = DEPTH_WORD[AW:0];

  reg  [AW-1:0] wptr_r;
  reg  [AW-1:0] rptr_r;
  reg  [AW:0]   count_r;
  wire          push;
  wire          pop;
  wire [AW-1:0] raddr;
  wire [AW:0]   count_nxt;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign raddr     = pop ? rptr_r + 1'b1 : rptr_r;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  word_ram #(.W(W), .AW(AW)) u_ram (
    .ref_clk (ref_clk),
    .we      (push),
    .waddr   (wptr_r),
    .wdata   (in_data),
    .raddr   (raddr),
    .rdata   (out_data)
  );

  // a word written where it is read this cycle reaches rdata one cycle late
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wptr_r    <= {AW{1'b0}};
      rptr_r    <= {AW{1'b0}};
      count_r   <= {(AW+1){1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop)
      begin
        rptr_r <= rptr_r + 1'b1;
      end
      count_r   <= count_nxt;
      in_ready  <= (count_nxt != FULL_CNT);
      out_valid <= (count_nxt != {(AW+1){1'b0}}) && !(push && (wptr_r == raddr));
    end
  end

endmodule // req_fifo

// file: verilog/ext_bus_addr_phase.v
`timescale 1ns/1ps
`include "ext_bus_consts.vh"

module ext_bus_addr_phase (
  input  wire                     ref_clk,
  input  wire                     rst,
  input  wire                     req_valid,
  input  wire [`EB_ADDR_W-1:0]    req_addr,
  input  wire                     req_read,
  input  wire [1:0]               req_size,
  input  wire                     req_burst,
  input  wire [3:0]               req_class,
  input  wire                     req_reserve,
  input  wire                     req_trace,
  input  wire                     req_cond_store,
  output wire                     req_ready,
  input  wire                     set_reservation,
  input  wire                     bus_clk,
  output reg  [0:`EB_PIN_ADDR_W-1] addr_pin,
  output reg                      rd_wr_pin,
  output reg                      burst_pin_n,
  output reg  [0:1]               byte_count_code,
  output reg  [0:3]               access_class_code,
  output reg                      reserve_marker_n,
  output reg                      trace_flow_marker,
  output reg                      cycle_begin_strobe_n,
  output reg                      next_beat_request_n,
  output reg                      pins_oe_n,
  input  wire                     strobe_seen_n,
  input  wire                     burst_seen_n,
  input  wire                     beat_acknowledge_n,
  input  wire                     drop_lock_pulse_n,
  input  wire                     abort_conditional_store_n,
  output reg                      beat_taken,
  output reg                      cycle_done,
  output reg                      cycle_aborted,
  output reg                      reservation_held,
  output reg                      burst_refused
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ADDR = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;

  // ----------------------------------------
  // pin input synchronisers
  // ----------------------------------------
  reg  [`EB_IN_W-1:0] in_s1_r;
  reg  [`EB_IN_W-1:0] in_s2_r;
  reg  [`EB_IN_W-1:0] in_s3_r;
  wire                bus_edge;
  wire                ack_now;
  wire                abort_now;
  wire                drop_now;

  // a pin caught mid-transition settles in the first stage; only stages two and three are read
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      in_s1_r  <= {`EB_IN_W{1'b1}};
      in_s2_r  <= {`EB_IN_W{1'b1}};
      in_s3_r  <= {`EB_IN_W{1'b1}};
    end
    else
    begin
      in_s1_r  <= {abort_conditional_store_n, drop_lock_pulse_n, beat_acknowledge_n,
                   burst_seen_n, strobe_seen_n, bus_clk};
      in_s2_r  <= in_s1_r;
      in_s3_r  <= in_s2_r;
    end
  end

  // ----------------------------------------
  // edge sampling and burst helpers
  // ----------------------------------------
  // an active-low input counts only at a detected bus edge
  function edge_low;
    input at_edge;
    input level_n;
    begin
      edge_low = at_edge & ~level_n;
    end
  endfunction

  // bursts are word-only and fixed at four beats; narrow ports sit behind
  // the memory controller, which splits wide operands for them
  function burst_honoured;
    input       want_burst;
    input [1:0] size_code;
    begin
      burst_honoured = want_burst & (size_code == `EB_SZ_FOUR);
    end
  endfunction

  // stage three holds the level from just before the pin edge, the one the
  // far side launched a bus clock earlier; the level after the edge may be
  // the next one already; works for a full- or half-rate bus clock
  assign bus_edge  = in_s2_r[`EB_IN_CLK] & ~in_s3_r[`EB_IN_CLK];
  assign ack_now   = edge_low(bus_edge, in_s3_r[`EB_IN_ACK]);
  assign abort_now = edge_low(bus_edge, in_s3_r[`EB_IN_ABORT]);
  assign drop_now  = edge_low(bus_edge, in_s3_r[`EB_IN_DROP]);

  // ----------------------------------------
  // request queue
  // ----------------------------------------
  wire [`EB_REQ_W-1:0] req_word;
  wire [`EB_REQ_W-1:0] head;
  wire                 head_valid;
  wire                 take;

  assign req_word = {req_cond_store, req_trace, req_reserve, req_class, req_burst,
                     req_size, req_read, req_addr};

  // the queue only drains at a bus edge while idle, so a slow bus fills it
  req_fifo #(.W(`EB_REQ_W), .DEPTH(`EB_FIFO_DEPTH), .AW(`EB_FIFO_AW)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (req_valid),
    .in_data   (req_word),
    .in_ready  (req_ready),
    .out_valid (head_valid),
    .out_data  (head),
    .out_ready (take)
  );

  // ----------------------------------------
  // transfer state
  // ----------------------------------------
  reg  [1:0] state_r;
  reg  [1:0] beat_r;
  reg  [1:0] last_r;
  reg        cond_r;
  wire       head_burst;

  assign take = bus_edge & (state_r == ST_IDLE) & head_valid;

  assign head_burst = burst_honoured(head[`EB_F_BURST],
                                     head[`EB_F_SIZE_HI:`EB_F_SIZE_LO]);

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r              <= ST_IDLE;
      beat_r               <= 2'h0;
      last_r               <= 2'h0;
      cond_r               <= 1'b0;
      addr_pin             <= {`EB_PIN_ADDR_W{1'b0}};
      rd_wr_pin            <= 1'b1;
      burst_pin_n          <= 1'b1;
      byte_count_code      <= `EB_SZ_FOUR;
      access_class_code    <= 4'h0;
      reserve_marker_n     <= 1'b1;
      trace_flow_marker    <= 1'b0;
      cycle_begin_strobe_n <= 1'b1;
      next_beat_request_n  <= 1'b1;
      pins_oe_n            <= 1'b1;
      beat_taken           <= 1'b0;
      cycle_done           <= 1'b0;
      cycle_aborted        <= 1'b0;
    end
    else
    begin
      beat_taken    <= 1'b0;
      cycle_done    <= 1'b0;
      cycle_aborted <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (take)
          begin
            // all attributes change together with the strobe edge
            addr_pin          <= head[`EB_PIN_ADDR_W-1:0];
            byte_count_code   <= head[`EB_F_SIZE_HI:`EB_F_SIZE_LO];
            access_class_code <= head[`EB_F_CLASS_HI:`EB_F_CLASS_LO];
            reserve_marker_n  <= ~head[`EB_F_RESERVE];
            trace_flow_marker <= head[`EB_F_TRACE];
            burst_pin_n       <= ~head_burst;
            // direction is only loaded here, so it holds between cycles
            rd_wr_pin         <= head[`EB_F_READ];
            cycle_begin_strobe_n <= 1'b0;
            next_beat_request_n  <= ~head_burst;
            pins_oe_n         <= 1'b0;
            last_r            <= head_burst ? `EB_LAST_BEAT : 2'h0;
            beat_r            <= 2'h0;
            cond_r            <= head[`EB_F_COND];
            state_r           <= ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          // strobe lasts one bus clock; earliest ack is the next edge
          if (bus_edge)
          begin
            cycle_begin_strobe_n <= 1'b1;
            state_r              <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (cond_r && abort_now)
          begin
            // lost reservation: the far interface backs this store off
            cycle_aborted       <= 1'b1;
            next_beat_request_n <= 1'b1;
            pins_oe_n           <= 1'b1;
            state_r             <= ST_IDLE;
          end
          else if (ack_now)
          begin
            beat_taken <= 1'b1;
            if (beat_r == last_r)
            begin
              cycle_done          <= 1'b1;
              next_beat_request_n <= 1'b1;
              pins_oe_n           <= 1'b1;
              state_r             <= ST_IDLE;
            end
            else
            begin
              beat_r <= beat_r + 2'h1;
              // stop asking once the beat in flight is the last one
              if (beat_r + 2'h1 == last_r)
              begin
                next_beat_request_n <= 1'b1;
              end
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // storage reservation
  // ----------------------------------------
  // a local set in the same cycle as a cancel wins
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reservation_held <= 1'b0;
    end
    else if (set_reservation)
    begin
      reservation_held <= 1'b1;
    end
    else if (drop_now)
    begin
      reservation_held <= 1'b0;
    end
    else if ((state_r == ST_DATA) && cond_r && abort_now)
    begin
      reservation_held <= 1'b0;
    end
  end

  // ----------------------------------------
  // foreign master watch
  // ----------------------------------------
  // a burst started by another master toward this device is flagged,
  // not served; the data side uses the flag to inhibit it
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      burst_refused <= 1'b0;
    end
    else
    begin
      burst_refused <= edge_low(bus_edge & pins_oe_n, in_s3_r[`EB_IN_TS]) &
                       ~in_s3_r[`EB_IN_BURST];
    end
  end

endmodule // ext_bus_addr_phase

// file: tb/ext_bus_addr_phase_props.sv
`timescale 1ns/1ps
`include "ext_bus_consts.vh"

module ext_bus_addr_phase_props (
  input wire        ref_clk,
  input wire        rst,
  input wire [0:23] addr_pin,
  input wire        rd_wr_pin,
  input wire        burst_pin_n,
  input wire [0:1]  byte_count_code,
  input wire        cycle_begin_strobe_n,
  input wire        next_beat_request_n,
  input wire        pins_oe_n,
  input wire        cycle_done,
  input wire        cycle_aborted,
  input wire        reservation_held,
  input wire        set_reservation
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // cycle shape
  // ----------------------------------------
  // strobe spans one bus clock, 8 ref clocks give or take sync jitter
  sequence strobe_opens;
    $fell(cycle_begin_strobe_n);
  endsequence
  sequence strobe_one_clock;
    (!cycle_begin_strobe_n)[*6] ##[1:4] cycle_begin_strobe_n;
  endsequence

  a_strobe_width: assert property (strobe_opens |-> strobe_one_clock)
    else $error("strobe width off");
  a_burst_hold: assert property
    (strobe_opens ##0 !burst_pin_n |-> (!next_beat_request_n)[*8]) else $error("beat req");
  a_single_nbr: assert property
    (strobe_opens ##0 burst_pin_n |-> next_beat_request_n) else $error("single req");
  a_burst_size: assert property
    (!pins_oe_n && !burst_pin_n |-> byte_count_code == `EB_SZ_FOUR) else $error("burst size");
  a_dir_change: assert property
    ($changed(rd_wr_pin) |-> $fell(cycle_begin_strobe_n)) else $error("dir moved");
  a_attr_stable: assert property
    (!pins_oe_n && !$past(pins_oe_n) |-> $stable(addr_pin) && $stable(rd_wr_pin)
      && $stable(byte_count_code) && $stable(burst_pin_n)) else $error("attr moved");
  a_done_release: assert property
    (cycle_done |-> ##[0:1] pins_oe_n) else $error("pins kept");
  a_abort_unlock: assert property
    (cycle_aborted && !$past(set_reservation) |-> ##[0:1] !reservation_held)
    else $error("resv kept");
endmodule // ext_bus_addr_phase_props

// file: tb/bus_slave_model.sv
`timescale 1ns/1ps

// word-wide slave only; narrow ports sit behind the memory controller
module bus_slave_model (
  input wire bus_clk,
  input wire cycle_begin_strobe_n,
  input wire burst_pin_n,
  input wire pins_oe_n,
  input wire slow,
  input wire kill_en,
  output reg beat_acknowledge_n = 1'b1,
  output reg abort_conditional_store_n = 1'b1
);
  reg  [2:0] left = 3'h0;
  wire       start = left == 3'h0 && !cycle_begin_strobe_n && !pins_oe_n;
  wire [2:0] beats = start ? (burst_pin_n ? 3'h1 : 3'h4) : left;

  // lines are driven back high on a bus clock with no beat; back-to-back beats keep ack low
  always @(posedge bus_clk)
  begin
    beat_acknowledge_n <= 1'b1;
    abort_conditional_store_n <= 1'b1;
    left <= beats;
    if (beats != 3'h0 && !slow)
    begin
      beat_acknowledge_n <= 1'b0;
      abort_conditional_store_n <= !(kill_en && burst_pin_n);
      left <= beats - 3'h1;
    end
  end
endmodule // bus_slave_model

// file: tb/ext_bus_addr_phase_bench.sv
`timescale 1ns/1ps
`include "ext_bus_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end

module ext_bus_addr_phase_bench;
  typedef struct packed {
    logic        kill;
    logic        cond;
    logic        trace;
    logic        resv;
    logic [3:0]  cls;
    logic        burst;
    logic [1:0]  size;
    logic        rd;
    logic [31:0] a;
  } req_t;

  logic        ref_clk = 1'b0;
  logic        bus_clk = 1'b0;
  logic        rst = 1'b1;
  logic        slow = 1'b0;
  logic        kill_en = 1'b0;
  logic        set_reservation = 1'b0;
  logic        strobe_seen_n = 1'b1;
  logic        burst_seen_n = 1'b1;
  logic        drop_lock_pulse_n = 1'b1;
  logic        req_valid = 1'b0;
  logic        s_prev = 1'b1;
  logic        saw_full = 1'b0;
  logic [31:0] seed = 32'h68e7;
  logic [31:0] r;
  req_t        rq = '0;
  req_t        nx;
  req_t        cur;
  req_t        expq[$];
  int          failures = 0;
  int          samples_checked = 0;
  int          pending = 0;
  int          refused = 0;
  int          beats = 0;
  wire [0:23]  addr_pin;
  wire [0:1]   byte_count_code;
  wire [0:3]   access_class_code;
  wire         req_ready, rd_wr_pin, burst_pin_n, reserve_marker_n, trace_flow_marker;
  wire         cycle_begin_strobe_n, next_beat_request_n, pins_oe_n, beat_acknowledge_n;
  wire         abort_conditional_store_n, beat_taken, cycle_done, cycle_aborted;
  wire         reservation_held, burst_refused;

  ext_bus_addr_phase dut_u (.req_addr(rq.a), .req_read(rq.rd), .req_size(rq.size),
    .req_burst(rq.burst), .req_class(rq.cls), .req_reserve(rq.resv),
    .req_trace(rq.trace), .req_cond_store(rq.cond), .*);
  bus_slave_model slave_u (.*);

  always #25 ref_clk = ~ref_clk;
  initial
  begin
    #13;
    forever #200 bus_clk = ~bus_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic complete_run();
    $display("failures %0d checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // valid stays up between sends; caller drops it after the last one
  task automatic send(input req_t q);
    rq <= q;
    req_valid <= 1'b1;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    expq.push_back(q);
    pending++;
  endtask

  always @(posedge ref_clk)
    slow <= ^rnd();

  // ----------------------------------------
  // reference model compare
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rst)
    begin
      if (req_valid && req_ready === 1'b0)
        saw_full = 1'b1;
      if (burst_refused === 1'b1)
        refused++;
      if (s_prev && cycle_begin_strobe_n === 1'b0)
      begin
        cur = expq.pop_front();
        beats = 0;
        `CHK(addr_pin, cur.a[23:0])
        `CHK(rd_wr_pin, cur.rd)
        `CHK(byte_count_code, cur.size)
        `CHK(burst_pin_n, !(cur.burst && cur.size == `EB_SZ_FOUR))
        `CHK(access_class_code, cur.cls)
        `CHK({reserve_marker_n, trace_flow_marker}, {!cur.resv, cur.trace})
        `CHK(pins_oe_n, 1'b0)
      end
      s_prev = cycle_begin_strobe_n;
      beats += beat_taken === 1'b1;
      if (cycle_done === 1'b1 || cycle_aborted === 1'b1)
      begin
        pending--;
        `CHK(cycle_aborted, cur.kill && cur.cond)
        if (cycle_done === 1'b1)
          `CHK(beats, (cur.burst && cur.size == `EB_SZ_FOUR) ? 4 : 1)
      end
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    set_reservation <= 1'b1;
    @(posedge ref_clk);
    set_reservation <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(reservation_held, 1'b1)
    drop_lock_pulse_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    drop_lock_pulse_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK(reservation_held, 1'b0)
    for (int ph = 0; ph < 2; ph++)
    begin
      kill_en <= ph[0];
      set_reservation <= ph[0];
      @(posedge ref_clk);
      set_reservation <= 1'b0;
      for (int i = 0; i < 12; i++)
      begin
        r = rnd();
        nx = {r[11:0], rnd()};
        nx.kill = ph[0];
        if (ph == 1 && i == 0)
          nx.cond = 1'b1;
        if (nx.cond)
          nx.burst = 1'b0;
        send(nx);
      end
      req_valid <= 1'b0;
      for (int k = 0; k < 4000 && pending != 0; k++)
        @(posedge ref_clk);
      `CHK(pending, 0)
      `CHK(saw_full, 1'b1)
    end
    `CHK(reservation_held, 1'b0)
    for (int j = 0; j < 2; j++)
    begin
      strobe_seen_n <= 1'b0;
      burst_seen_n <= !j[0];
      repeat (8) @(posedge ref_clk);
      strobe_seen_n <= 1'b1;
      burst_seen_n <= 1'b1;
      repeat (20) @(posedge ref_clk);
    end
    `CHK(refused, 1)
    complete_run();
  end

  initial
  begin
    #1000000;
    failures++;
    complete_run();
  end
endmodule // ext_bus_addr_phase_bench

bind ext_bus_addr_phase ext_bus_addr_phase_props props_u (.*);
